// >>> include/spc_pkg.sv
// constants, types and helpers shared by the serial port control block
package spc_pkg;
  // =====================================================
  // register map
  localparam int DW = 32;
  localparam int AW = 8;
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_ST = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
  localparam logic [31:0] CTRL0_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL1_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL0_MASK = 32'h0060_001F;
  localparam logic [31:0] CTRL1_MASK = 32'h002F_DFFE;
  // =====================================================
  // field positions
  localparam int C0_SIZE = 0;
  localparam int C0_FMT = 21;
  localparam int C1_EN = 1;
  localparam int C1_ROLE = 2;
  localparam int C1_SOD = 3;
  localparam int C1_RXORD = 4;
  localparam int C1_WAIT = 6;
  localparam int C1_RXLVL = 7;
  localparam int C1_TXLVL = 10;
  localparam int C1_GAP = 14;
  localparam int C1_TXORD = 18;
  localparam int C1_DLY = 21;
  // =====================================================
  // encodings and counts
  localparam logic [1:0] FMT_STD = 2'h0;
  localparam logic [1:0] FMT_CMD = 2'h2;
  localparam logic [4:0] SIZE_MIN = 5'h03;
  localparam logic [2:0] LVL_1 = 3'h0;
  localparam logic [2:0] LVL_4 = 3'h1;
  localparam logic [2:0] LVL_8 = 3'h2;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_AW = 3;
  localparam int HALF_DIV_DEF = 8;
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_OVR = 2;
  localparam int IRQ_DONE = 3;
  localparam int IRQ_W = 4;
  typedef enum logic [2:0] {ST_IDLE, ST_SHIFT, ST_WAIT, ST_RECV, ST_GAP, ST_SLV} spc_state_t;
  // trigger level for a code; zero means reserved, never triggers
  function automatic logic [3:0] spc_level(input logic [2:0] code);
    logic [3:0] l;
    l = 4'h0;
    if (code == LVL_1) l = 4'h1;
    else if (code == LVL_4) l = 4'h4;
    else if (code == LVL_8) l = 4'h8;
    return l;
  endfunction
endpackage

// >>> hw/spc_fifo.sv
// element store with show-ahead head word and occupancy count
`timescale 1ns/1ns
module spc_fifo #(
  parameter int W = spc_pkg::DW,
  parameter int DEPTH = spc_pkg::FIFO_DEPTH,
  parameter int AW = spc_pkg::FIFO_AW
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic push_i,
  input wire logic [W-1:0] data_i,
  input wire logic pop_i,
  output logic [W-1:0] data_o,
  output logic [AW:0] count_o,
  output logic full_o,
  output logic empty_o
);
  import spc_pkg::*;
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  // pushes into a full store and pops from an empty one are dropped
  wire do_push = push_i & ~full_o;
  wire do_pop = pop_i & ~empty_o;
  assign data_o = mem[rptr];
  assign full_o = (count_o == (AW+1)'(DEPTH));
  assign empty_o = (count_o == '0);
  // pointers and count
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wptr <= '0;
      rptr <= '0;
      count_o <= '0;
    end else begin
      if (do_push) wptr <= wptr + 1'b1;
      if (do_pop) rptr <= rptr + 1'b1;
      count_o <= count_o + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
  // storage
  always_ff @(posedge clk_i) begin
    if (do_push) mem[wptr] <= data_i;
  end
endmodule

// >>> hw/spc_order.sv
// byte and bit reordering of one element held in the low bits
`timescale 1ns/1ns
module spc_order (
  input wire logic [spc_pkg::DW-1:0] data_i,
  input wire logic [4:0] size_i,
  input wire logic [1:0] code_i,
  output logic [spc_pkg::DW-1:0] data_o
);
  import spc_pkg::*;
  // mirror the low n bits
  function automatic logic [31:0] rev_bits(input logic [31:0] d, input logic [5:0] n);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      if (i < int'(n)) r[i] = d[int'(n) - 1 - i];
    end
    return r;
  endfunction
  // reverse whole bytes when the element is 16, 24 or 32 bits
  function automatic logic [31:0] swap_bytes(input logic [31:0] d, input logic [5:0] n);
    logic [31:0] r;
    r = d;
    if (n[2:0] == 3'h0 && n >= 6'h10) begin
      for (int j = 0; j < 4; j++) begin
        if (j < int'(n[5:3])) r[8*j +: 8] = d[8*(int'(n[5:3]) - 1 - j) +: 8];
      end
    end
    return r;
  endfunction
  wire [5:0] nbits = {1'b0, size_i} + 6'h01;
  // code 01 swaps bytes, 11 mirrors bits, 10 does both; both are involutions
  wire do_swap = code_i[0] ^ code_i[1];
  wire [31:0] swapped = do_swap ? swap_bytes(data_i, nbits) : data_i;
  assign data_o = code_i[1] ? rev_bits(swapped, nbits) : swapped;
endmodule

// >>> hw/spc_top.sv
// serial port controller: register file, shift engine, interrupts
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
// How it works
// R1: bit 1 enables the port; bit 2 clear is master, set is slave.
// R2: slave with output-disable set never drives the slave data output.
// R3: receive ordering 5:4 picks byte order and bit order of received elements.
// R4: transmit ordering 19:18 uses the same four codes for shifted-out elements.
// R5: software uses byte-swap codes only with 16, 24 or 32 bit elements.
// R6: command format inserts one wait state when bit 6 is set.
// R7: receive trigger 9:7 fires at 1, 4 or 8 held elements.
// R8: transmit trigger 12:10 fires at 1, 4 or 8 held elements.
// R9: standard format waits bits 17:14 bit periods between frames.
// R10: bit 21 delays the data input path by two clocks.
// R11: element length is size field plus one; codes below 3 act as 4 bits.
// R12: format code 0 is standard serial, code 2 is command/response.
// R13: trigger conditions follow occupancy and threshold every cycle.
module spc_top #(
  parameter int HALF_DIV = spc_pkg::HALF_DIV_DEF
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [spc_pkg::AW-1:0] paddr_i,
  input wire logic [spc_pkg::DW-1:0] pwdata_i,
  output logic [spc_pkg::DW-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oen_o,
  input wire logic cs_n_i,
  output logic cs_n_o,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oen_o,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oen_o
);
  import spc_pkg::*;
  localparam logic [7:0] HALF_LAST = 8'(HALF_DIV - 1);
  // =====================================================
  // registers and fields
  logic [31:0] ctrl0, serial_control_two;
  logic [IRQ_W-1:0] irq_en, irq_st;
  wire port_enable_bit = serial_control_two[C1_EN];
  wire role_select = serial_control_two[C1_ROLE];
  wire slave_output_disable = serial_control_two[C1_SOD];
  wire [1:0] rx_byte_bit_order = serial_control_two[C1_RXORD +: 2];
  wire cmd_format_wait_state = serial_control_two[C1_WAIT];
  wire [2:0] rx_fifo_trigger_level = serial_control_two[C1_RXLVL +: 3];
  wire [2:0] tx_fifo_trigger_level = serial_control_two[C1_TXLVL +: 3];
  wire [3:0] inter_frame_gap = serial_control_two[C1_GAP +: 4];
  wire [1:0] tx_byte_bit_order = serial_control_two[C1_TXORD +: 2];
  wire input_path_delay = serial_control_two[C1_DLY];
  wire [4:0] frame_size_field = ctrl0[C0_SIZE +: 5];
  wire [1:0] frame_format_select = ctrl0[C0_FMT +: 2];
  // reserved short sizes are treated as the shortest legal element
  wire [4:0] fsize = (frame_size_field < SIZE_MIN) ? SIZE_MIN : frame_size_field; // R11
  wire fmt_cmd = (frame_format_select == FMT_CMD); // R12
  wire mst_on = port_enable_bit & ~role_select; // R1
  wire slv_on = port_enable_bit & role_select; // R1

  // =====================================================
  // pin synchronisers and optional input delay
  logic [3:0] sync1, sync2;
  logic sclk_q, dly1, dly2;
  wire s_sclk = sync2[3];
  wire s_csn = sync2[2];
  wire rx_sel = role_select ? sync2[1] : sync2[0];
  wire rx_bit = input_path_delay ? dly2 : rx_sel; // R10
  wire s_rise = s_sclk & ~sclk_q;
  wire s_fall = ~s_sclk & sclk_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1 <= 4'h4;
      sync2 <= 4'h4;
      sclk_q <= 1'b0;
      dly1 <= 1'b0;
      dly2 <= 1'b0;
    end else begin
      sync1 <= {sclk_i, cs_n_i, mosi_i, miso_i};
      sync2 <= sync1;
      sclk_q <= s_sclk;
      dly1 <= rx_sel;
      dly2 <= dly1;
    end
  end

  // =====================================================
  // element stores and reordering
  logic [31:0] tx_head, tx_word, rx_word, rx_head, rsreg;
  logic [FIFO_AW:0] tx_count, rx_count;
  logic tx_full, tx_empty, rx_full, rx_empty;
  logic tx_push, tx_pop, rx_push, rx_pop;
  spc_fifo #(.W(DW), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_txf (
    .clk_i(clk_i), .rstn_i(rstn_i), .push_i(tx_push), .data_i(pwdata_i),
    .pop_i(tx_pop), .data_o(tx_head), .count_o(tx_count), .full_o(tx_full),
    .empty_o(tx_empty)
  );
  spc_fifo #(.W(DW), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_rxf (
    .clk_i(clk_i), .rstn_i(rstn_i), .push_i(rx_push), .data_i(rx_word),
    .pop_i(rx_pop), .data_o(rx_head), .count_o(rx_count), .full_o(rx_full),
    .empty_o(rx_empty)
  );
  // outgoing element reordered, then left aligned for msb-first shifting
  spc_order u_txo (.data_i(tx_head), .size_i(fsize), .code_i(tx_byte_bit_order),
    .data_o(tx_word)); // R4
  spc_order u_rxo (.data_i(rsreg), .size_i(fsize), .code_i(rx_byte_bit_order),
    .data_o(rx_word)); // R3
  wire [31:0] tx_algn = tx_empty ? 32'h0000_0000 : (tx_word << (5'h1F - fsize));

  // =====================================================
  // shift engine
  spc_state_t state;
  logic [31:0] sreg;
  logic [4:0] bitcnt;
  logic [7:0] hcnt;
  logic [3:0] gcnt;
  logic phase, pend;
  wire tick = (hcnt == HALF_LAST);
  wire last = tick & phase & (bitcnt == 5'h00);
  wire mst_go = (state == ST_IDLE) & mst_on & ~tx_empty;
  wire slv_go = (state == ST_IDLE) & slv_on & ~s_csn;
  wire slv_reload = (state == ST_SLV) & s_fall & pend;
  wire mst_push = last & ((state == ST_SHIFT & ~fmt_cmd) | state == ST_RECV);
  // the engine moves the stores only on its own element boundaries; bus pushes and pops come at any time
  assign tx_pop = (mst_go | slv_go | slv_reload) & ~tx_empty;
  assign rx_push = mst_push | slv_reload;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= ST_IDLE;
      sreg <= 32'h0000_0000;
      rsreg <= 32'h0000_0000;
      bitcnt <= 5'h00;
      hcnt <= 8'h00;
      gcnt <= 4'h0;
      phase <= 1'b0;
      pend <= 1'b0;
      sclk_o <= 1'b0;
      cs_n_o <= 1'b1;
    end else if (!port_enable_bit) begin
      state <= ST_IDLE; // R1
      sclk_o <= 1'b0;
      cs_n_o <= 1'b1;
      hcnt <= 8'h00;
      phase <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          hcnt <= 8'h00;
          phase <= 1'b0;
          pend <= 1'b0;
          sclk_o <= 1'b0;
          cs_n_o <= 1'b1;
          sreg <= tx_algn;
          rsreg <= 32'h0000_0000;
          bitcnt <= fsize;
          if (mst_go) begin
            state <= ST_SHIFT;
            cs_n_o <= 1'b0;
          end else if (slv_go) begin
            state <= ST_SLV;
          end
        end
        ST_SHIFT, ST_WAIT, ST_RECV: begin
          hcnt <= tick ? 8'h00 : hcnt + 8'h01;
          if (tick) begin
            phase <= ~phase;
            sclk_o <= ~phase;
            if (!phase) begin
              if (state != ST_WAIT) rsreg <= {rsreg[30:0], rx_bit};
            end else if (bitcnt != 5'h00) begin
              bitcnt <= bitcnt - 5'h01;
              sreg <= {sreg[30:0], 1'b0};
            end else if (state == ST_SHIFT && fmt_cmd) begin
              state <= cmd_format_wait_state ? ST_WAIT : ST_RECV; // R6
              bitcnt <= cmd_format_wait_state ? 5'h00 : fsize;
              rsreg <= 32'h0000_0000;
            end else if (state == ST_WAIT) begin
              state <= ST_RECV;
              bitcnt <= fsize;
              rsreg <= 32'h0000_0000;
            end else begin
              state <= (!fmt_cmd && inter_frame_gap != 4'h0) ? ST_GAP : ST_IDLE; // R9
              gcnt <= inter_frame_gap;
              cs_n_o <= 1'b1;
            end
          end
        end
        ST_GAP: begin
          hcnt <= tick ? 8'h00 : hcnt + 8'h01;
          if (tick) phase <= ~phase;
          if (tick && phase) begin
            gcnt <= gcnt - 4'h1; // R9
            if (gcnt == 4'h1) state <= ST_IDLE;
          end
        end
        ST_SLV: begin
          if (s_csn) begin
            state <= ST_IDLE;
          end else if (s_rise) begin
            rsreg <= {rsreg[30:0], rx_bit};
            if (bitcnt == 5'h00) begin
              pend <= 1'b1;
              bitcnt <= fsize;
            end else begin
              bitcnt <= bitcnt - 5'h01;
            end
          end else if (s_fall) begin
            pend <= 1'b0;
            sreg <= pend ? tx_algn : {sreg[30:0], 1'b0};
            if (pend) rsreg <= 32'h0000_0000;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
  // pin drivers; enables are low while driving
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mosi_o <= 1'b0;
      miso_o <= 1'b0;
      sclk_oen_o <= 1'b1;
      mosi_oen_o <= 1'b1;
      miso_oen_o <= 1'b1;
    end else begin
      mosi_o <= (state == ST_SHIFT) & sreg[31];
      miso_o <= (state == ST_SLV) & sreg[31];
      sclk_oen_o <= ~mst_on; // R1
      mosi_oen_o <= ~mst_on;
      miso_oen_o <= ~(slv_on & ~slave_output_disable & ~s_csn); // R2
    end
  end

  // =====================================================
  // interrupt events
  wire [3:0] rx_lvl = spc_level(rx_fifo_trigger_level);
  wire [3:0] tx_lvl = spc_level(tx_fifo_trigger_level);
  wire rx_trig = (rx_lvl != 4'h0) && ({1'b0, rx_count} >= {1'b0, rx_lvl}); // R7 R13
  wire tx_trig = (tx_lvl != 4'h0) && ({1'b0, tx_count} >= {1'b0, tx_lvl}); // R8 R13
  wire [IRQ_W-1:0] ev = {rx_push, rx_push & rx_full, tx_trig, rx_trig};

  // =====================================================
  // bus slave decode
  wire acc_1st = psel_i & penable_i & ~pready_o;
  wire acc_end = psel_i & penable_i & pready_o;
  wire wr = acc_end & pwrite_i;
  wire hit_c0 = (paddr_i == OFS_CTRL0);
  wire hit_c1 = (paddr_i == OFS_CTRL1);
  wire hit_dat = (paddr_i == OFS_DATA);
  wire hit_st = (paddr_i == OFS_STAT);
  wire hit_ist = (paddr_i == OFS_IRQ_ST);
  wire hit_ien = (paddr_i == OFS_IRQ_EN);
  wire hit_clr = (paddr_i == OFS_IRQ_CLR);
  wire mapped = hit_c0 | hit_c1 | hit_dat | hit_st | hit_ist | hit_ien | hit_clr;
  wire busy = (state != ST_IDLE) | ~tx_empty;
  wire [31:0] stat = {27'h0, busy, rx_full, ~rx_empty, ~tx_full, tx_empty};
  wire [31:0] rdata;
  assign rdata = hit_c0 ? ctrl0 :
                 hit_c1 ? serial_control_two :
                 hit_dat ? (rx_empty ? 32'h0000_0000 : rx_head) : // empty store reads zero
                 hit_st ? stat :
                 hit_ist ? {28'h0, irq_st} :
                 hit_ien ? {28'h0, irq_en} : 32'h0000_0000;
  wire [IRQ_W-1:0] clr = (wr & hit_clr) ? pwdata_i[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] next_irq_st = (irq_st & ~clr) | ev;
  assign tx_push = wr & hit_dat;
  assign rx_pop = acc_end & ~pwrite_i & hit_dat;
  // registers, answer and interrupt line
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl0 <= CTRL0_RST;
      serial_control_two <= CTRL1_RST;
      irq_en <= '0;
      irq_st <= '0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      irq_o <= 1'b0;
    end else begin
      if (wr && hit_c0) ctrl0 <= pwdata_i & CTRL0_MASK;
      if (wr && hit_c1) serial_control_two <= pwdata_i & CTRL1_MASK;
      if (wr && hit_ien) irq_en <= pwdata_i[IRQ_W-1:0];
      irq_st <= next_irq_st;
      pready_o <= acc_1st;
      pslverr_o <= acc_1st & ~mapped;
      if (acc_1st && !pwrite_i) prdata_o <= rdata;
      irq_o <= |(next_irq_st & irq_en);
    end
  end

  // =====================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  en_off_idle_a: assert property (!port_enable_bit |=> state == ST_IDLE) // R1
    else $error("engine active while port disabled");
  role_drive_a: assert property (mst_on |=> !sclk_oen_o ##0 miso_oen_o) // R1
    else $error("master pin drive wrong");
  sod_quiet_a: assert property (slv_on && slave_output_disable |=> miso_oen_o) // R2
    else $error("slave output driven while disabled");
  rx_mirror_a: assert property (rx_byte_bit_order == 2'h3 && fsize == 5'h0F |->
    rx_word[15:0] == {<<{rsreg[15:0]}}) // R3
    else $error("receive bit mirror wrong");
  tx_swap_a: assert property (tx_byte_bit_order == 2'h1 && fsize == 5'h0F |->
    tx_word[15:0] == {tx_head[7:0], tx_head[15:8]}) // R4
    else $error("transmit byte swap wrong");
  cmd_wait_a: assert property (last && state == ST_SHIFT && fmt_cmd &&
    cmd_format_wait_state && port_enable_bit |=> state == ST_WAIT) // R6
    else $error("wait state missing");
  rx_trig_a: assert property (rx_fifo_trigger_level == LVL_4 && rx_count >= 4'h4 |=>
    irq_st[IRQ_RX]) // R7
    else $error("receive trigger missed");
  tx_trig_a: assert property (tx_fifo_trigger_level == LVL_8 && tx_count < 4'h8 |->
    !ev[IRQ_TX]) // R8
    else $error("transmit trigger early");
  gap_end_a: assert property (state == ST_GAP && tick && phase && gcnt == 4'h1 &&
    port_enable_bit |=> state == ST_IDLE) // R9
    else $error("gap did not end");
  in_dly_a: assert property (input_path_delay && $stable(role_select) [*3] |->
    rx_bit == $past(rx_sel, 2)) // R10
    else $error("input delay wrong");
  size_min_a: assert property (fsize >= SIZE_MIN) // R11
    else $error("element shorter than four bits");
  recv_fmt_a: assert property (state == ST_RECV |-> fmt_cmd) // R12
    else $error("receive phase outside command format");
  mst_frame_c: cover property (mst_push && !fmt_cmd);
  cmd_wait_c: cover property (state == ST_WAIT ##1 state == ST_RECV);
  slv_elem_c: cover property (slv_reload);
  irq_c: cover property ($rose(irq_o));
endmodule

// >>> bench/spc_slave_model.sv
// far-side slave device model facing the master role, clock mode 0
`timescale 1ns/1ns
module spc_slave_model (
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  input wire logic [15:0] tx_word_i,
  output logic miso_o,
  output logic [15:0] rx_word_o
);
  logic [15:0] sh;
  initial begin
    sh = 16'h0000;
    miso_o = 1'b0;
    rx_word_o = 16'h0000;
  end
  // load on select and present the top bit
  always @(negedge cs_n_i) begin
    sh = tx_word_i;
    miso_o = sh[15];
  end
  // shift out on the falling clock
  always @(negedge sclk_i) if (!cs_n_i) begin
    sh = {sh[14:0], 1'b0};
    miso_o = sh[15];
  end
  // released line shows the inverse, not a stale bit
  always @(posedge cs_n_i) miso_o = ~miso_o;
  // sample on the rising clock
  always @(posedge sclk_i) if (!cs_n_i) rx_word_o = {rx_word_o[14:0], mosi_i};
endmodule

// >>> bench/tb_top.sv
// self-checking bench for the serial port controller
`timescale 1ns/1ns
module tb_top;
  import spc_pkg::*;
  localparam int HD = 8;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic sclk_i = 1'b0;
  logic cs_n_i = 1'b1;
  logic mosi_i = 1'b0;
  logic lerr;
  logic [15:0] ptx = 16'h0000;
  logic [31:0] prdata;
  logic [15:0] prx;
  logic pready, pslverr, irq, sclk_o, sclk_oen, cs_n_o, mosi_o, mosi_oen, miso_m, miso_o, miso_oen;
  int err_total = 0;
  int comparisons = 0;
  int pulses = 0;
  integer seed = 32'haeb0c5d5;
  // =====================================================
  // clock, design and far side
  always #25 clk_i = ~clk_i;
  always @(posedge sclk_o) pulses++;
  spc_top #(.HALF_DIV(HD)) u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq),
    .sclk_i(sclk_i), .sclk_o(sclk_o), .sclk_oen_o(sclk_oen), .cs_n_i(cs_n_i),
    .cs_n_o(cs_n_o), .mosi_i(mosi_i), .mosi_o(mosi_o), .mosi_oen_o(mosi_oen),
    .miso_i(miso_m), .miso_o(miso_o), .miso_oen_o(miso_oen));
  spc_slave_model u_far (.sclk_i(sclk_o), .cs_n_i(cs_n_o), .mosi_i(mosi_o),
    .tx_word_i(ptx), .miso_o(miso_m), .rx_word_o(prx));
  // =====================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one bus transfer, request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    lerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) chk(32'h0, 32'h1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    apb(1'b0, a, 32'h0, r);
  endtask
  task automatic wait_idle();
    logic [31:0] r;
    int n;
    n = 0;
    do begin
      rd(OFS_STAT, r);
      n++;
    end while (r[4] !== 1'b0 && n < 2000);
    if (r[4] !== 1'b0) chk(32'h0, 32'h1);
  endtask
  task automatic gap_len(output int g);
    int n;
    n = 0;
    g = 0;
    while (cs_n_o !== 1'b0 && n < 900) begin
      @(posedge clk_i);
      n++;
    end
    while (cs_n_o !== 1'b1 && n < 900) begin
      @(posedge clk_i);
      n++;
    end
    while (cs_n_o === 1'b1 && g < 900) begin
      @(posedge clk_i);
      g++;
    end
  endtask
  // wire order of a 16-bit element: byte swap, then bit mirror per byte
  function automatic logic [15:0] ord(input logic [15:0] d, input logic [1:0] c);
    logic [15:0] s;
    logic [15:0] r;
    s = c[0] ? {d[7:0], d[15:8]} : d;
    for (int i = 0; i < 16; i++) r[i] = c[1] ? s[i ^ 7] : s[i];
    return r;
  endfunction
  function automatic logic trig(input int c, input int n);
    int l;
    l = (c == 0) ? 1 : (c == 1) ? 4 : (c == 2) ? 8 : 0;
    return (l != 0) && (n >= l);
  endfunction
  task automatic complete_run();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // =====================================================
  // watchdog
  initial begin
    #3000000;
    err_total++;
    complete_run();
  end
  // =====================================================
  // main sequence
  initial begin
    logic [31:0] r;
    logic [31:0] d;
    int g0;
    int g5;
    logic [3:0] q;
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(OFS_CTRL1, r);
    chk(r, CTRL1_RST);
    rd(8'hFC, r);
    chk(r, 32'h0000_0000);
    chk({31'h0, lerr}, 32'h1);
    repeat (6) begin
      d = $random(seed) & 32'hFFFF_FFFD;
      wr(OFS_CTRL1, d);
      rd(OFS_CTRL1, r);
      chk(r, d & CTRL1_MASK);
    end
    wr(OFS_CTRL0, 32'h0000_000F);
    for (int k = 1; k <= 8; k++) begin
      wr(OFS_DATA, $random(seed));
      chk({sclk_oen, cs_n_o}, 2'b11);
      for (int c = 0; c < 4; c++) begin
        wr(OFS_CTRL1, c << C1_TXLVL);
        wr(OFS_IRQ_CLR, 32'h0000_000F);
        rd(OFS_IRQ_ST, r);
        chk(r[IRQ_TX], trig(c, k));
      end
    end
    wr(OFS_CTRL1, 32'h0);
    wr(OFS_IRQ_EN, 32'h2);
    repeat (3) @(posedge clk_i);
    chk(irq, 1'b1);
    wr(OFS_IRQ_EN, 32'h0);
    repeat (3) @(posedge clk_i);
    chk(irq, 1'b0);
    ptx = 16'($random(seed));
    wr(OFS_CTRL1, 32'h2);
    wait_idle();
    chk({sclk_oen, mosi_oen}, 2'b00);
    for (int k = 8; k > 0; k--) begin
      for (int c = 0; c < 4; c++) begin
        wr(OFS_CTRL1, 32'h2 | (c << C1_RXLVL));
        wr(OFS_IRQ_CLR, 32'h0000_000F);
        rd(OFS_IRQ_ST, r);
        chk(r[IRQ_RX], trig(c, k));
      end
      rd(OFS_DATA, r);
    end
    // byte swap codes only with 16-bit elements
    for (int c = 0; c < 4; c++) begin
      ptx = 16'($random(seed));
      d = $random(seed) & 32'h0000_FFFF;
      wr(OFS_CTRL1, 32'h2 | (c << C1_RXORD) | (c << C1_TXORD) | ((c == 2) << C1_DLY));
      wr(OFS_DATA, d);
      wait_idle();
      chk({16'h0000, prx}, {16'h0000, ord(d[15:0], c)});
      rd(OFS_DATA, r);
      chk(r, {16'h0000, ord(ptx, c)});
    end
    wr(OFS_CTRL0, 32'h3 | (FMT_CMD << C0_FMT));
    for (int w = 0; w < 2; w++) begin
      wr(OFS_CTRL1, 32'h2 | (w << C1_WAIT));
      pulses = 0;
      wr(OFS_DATA, $random(seed));
      wait_idle();
      chk(pulses, 8 + w);
    end
    wr(OFS_CTRL0, 32'h3);
    for (int g = 0; g < 6; g += 5) begin
      wr(OFS_CTRL1, 32'h2 | (g << C1_GAP));
      pulses = 0;
      wr(OFS_DATA, $random(seed));
      wr(OFS_DATA, $random(seed));
      if (g == 0) gap_len(g0);
      else gap_len(g5);
      wait_idle();
      chk(pulses, 8);
    end
    chk(g5 - g0, 5 * 2 * HD);
    do begin
      rd(OFS_DATA, r);
      rd(OFS_STAT, r);
      g0++;
    end while (r[2] !== 1'b0 && g0 < 40);
    // slave role: output disable, then one 4-bit element each way
    d = $random(seed) & 32'hFF;
    wr(OFS_CTRL1, 32'hE);
    wr(OFS_DATA, {28'h0, d[7:4]});
    cs_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk(miso_oen, 1'b1);
    chk({sclk_oen, mosi_oen}, 2'b11);
    wr(OFS_CTRL1, 32'h6);
    repeat (6) @(posedge clk_i);
    chk(miso_oen, 1'b0);
    for (int b = 3; b >= 0; b--) begin
      mosi_i <= d[b];
      repeat (4) @(posedge clk_i);
      sclk_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      q[b] = miso_o;
      sclk_i <= 1'b0;
    end
    chk(q, d[7:4]);
    repeat (4) @(posedge clk_i);
    cs_n_i <= 1'b1;
    mosi_i <= ~d[0];
    repeat (8) @(posedge clk_i);
    rd(OFS_DATA, r);
    chk(r, d & 32'hF);
    complete_run();
  end
endmodule
